/* hw/srasl_pkg.sv */
// package for the two-wire register access slave: offsets, layouts, states
package srasl_pkg;
  // software port byte offsets
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00; // sticky events, read clears
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h04; // event enables
  localparam logic [7:0] OFS_DIAG       = 8'h08; // {critical[12:7], flags[6:0]}
  localparam logic [7:0] OFS_NVC        = 8'h0c; // nv_write_cycle_count
  localparam logic [7:0] OFS_LINK       = 8'h10; // link status, read only
  localparam logic [7:0] OFS_REGS       = 8'h80; // register file, index in addr[6:2]
  // serial register indices with special read layout
  localparam logic [4:0] IDX_NVCTRL = 5'h1c;
  localparam logic [4:0] IDX_DIAG   = 5'h1e;
  // interrupt bit positions
  localparam int IRQ_WORD_WR  = 0;
  localparam int IRQ_WORD_RD  = 1;
  localparam int IRQ_STOP     = 2;
  localparam int IRQ_ADDR_BAD = 3;
  // bit count that closes a byte
  localparam logic [3:0] BIT_LAST = 4'h8;
  // reset values
  localparam logic [3:0]  RST_MASK = 4'h0;
  localparam logic [12:0] RST_DIAG = 13'h0000;
  localparam logic [9:0]  RST_NVC  = 10'h000;

  // serial sequence states, one-hot
  typedef enum logic [7:0] {
    SRASL_ST_IDLE     = 8'h01,
    SRASL_ST_ADDR     = 8'h02,
    SRASL_ST_ADDR_ACK = 8'h04,
    SRASL_ST_WR_BYTE  = 8'h08,
    SRASL_ST_WR_ACK   = 8'h10,
    SRASL_ST_RD_BYTE  = 8'h20,
    SRASL_ST_RD_ACK   = 8'h40,
    SRASL_ST_WAIT     = 8'h80
  } srasl_fsm_t;

  typedef logic [31:0][9:0] srasl_regs_t; // 32 words of 10 stored bits

  // whole state of the slave
  typedef struct packed {
    logic        scl_s1, scl_s2, scl_s3;
    logic        sda_s1, sda_s2, sda_s3;
    logic        uv_s1, uv_s2;
    srasl_fsm_t  fsm;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  byte_buf;
    logic [4:0]  idx;
    logic        half;
    logic        rw;
    logic        rd_ack;
    logic        oe_n;
    logic        sda_lvl;
    srasl_regs_t regs;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [12:0] diag;
    logic [9:0]  nvc;
    logic [31:0] rdata;
    logic        irq;
  } srasl_state_t;

  localparam srasl_state_t SRASL_RST = '{fsm: SRASL_ST_IDLE, scl_s1: 1'b1, scl_s2: 1'b1,
    scl_s3: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, oe_n: 1'b1,
    mask: RST_MASK, diag: RST_DIAG, nvc: RST_NVC, default: '0};
endpackage : srasl_pkg

/* hw/srasl_slave.sv */
// two-wire serial register access slave with software port and interrupt
module srasl_slave (
  input  wire logic        clk_sys_in,         // 125 MHz system clock
  input  wire logic        sys_rst_in,         // synchronous, active high
  input  wire logic        scl_in,             // serial clock pin, asynchronous
  input  wire logic        sda_in,             // serial data pin level
  output logic             sda_out,            // open-drain value, always low
  output logic             sda_oe_n_out,       // low while pulling SDA low
  input  wire logic        logic_supply_uv_in, // logic supply below threshold
  input  wire logic [7:0]  bus_addr_in,        // software byte address
  input  wire logic [31:0] bus_wdata_in,       // software write data
  input  wire logic        bus_wr_in,          // write strobe
  input  wire logic        bus_rd_in,          // read strobe
  output logic [31:0]      bus_rdata_out,      // read data, cycle after strobe
  output logic             irq_out             // level interrupt
);

  srasl_pkg::srasl_state_t st;   // registered state
  srasl_pkg::srasl_state_t nx;   // next state

  logic scl_rise;    // synced SCL went high
  logic scl_fall;    // synced SCL went low
  logic start_cond;  // SDA fell while SCL high
  logic stop_cond;   // SDA rose while SCL high
  logic commit;      // a full write word is stored this cycle
  logic [15:0] word; // word loaded for transmission

  // compose a read word: critical flags over register contents, or over nvc at index 28 or diag flags at 30
  function automatic logic [15:0] srasl_read_word(input srasl_pkg::srasl_regs_t regs,
                                                   input logic [12:0] diag,
                                                   input logic [9:0]  nvc,
                                                   input logic [4:0]  idx);
    logic [9:0] low;
    if (idx == srasl_pkg::IDX_NVCTRL) begin
      low = nvc;
    end else if (idx == srasl_pkg::IDX_DIAG) begin
      low = {diag[6:0], 3'b000};
    end else begin
      low = regs[idx];
    end
    return {diag[12:7], low};
  endfunction : srasl_read_word

  // edges only from second and third stages; first stage feeds nothing else
  assign scl_rise   = st.scl_s2 & ~st.scl_s3;
  assign scl_fall   = ~st.scl_s2 & st.scl_s3;
  assign start_cond = st.scl_s2 & st.scl_s3 & ~st.sda_s2 & st.sda_s3;
  assign stop_cond  = st.scl_s2 & st.scl_s3 & st.sda_s2 & ~st.sda_s3;

  // next-state logic for sync, serial sequence and software port
  always_comb begin
    nx     = st;
    commit = 1'b0;
    word   = 16'h0000;
    // synchronisers
    nx.scl_s1 = scl_in;
    nx.scl_s2 = st.scl_s1;
    nx.scl_s3 = st.scl_s2;
    nx.sda_s1 = sda_in;
    nx.sda_s2 = st.sda_s1;
    nx.sda_s3 = st.sda_s2;
    nx.uv_s1  = logic_supply_uv_in;
    nx.uv_s2  = st.uv_s1;
    nx.rdata  = 32'h0000_0000;
    // read clear first so an event in the same cycle still sets
    if (bus_rd_in && bus_addr_in == srasl_pkg::OFS_IRQ_STATUS) begin
      nx.status = 4'h0;
    end
    // software writes; serial commits below take priority
    if (bus_wr_in) begin
      if (bus_addr_in == srasl_pkg::OFS_IRQ_MASK) begin
        nx.mask = bus_wdata_in[3:0];
      end else if (bus_addr_in == srasl_pkg::OFS_DIAG) begin
        nx.diag = bus_wdata_in[12:0];
      end else if (bus_addr_in == srasl_pkg::OFS_NVC) begin
        nx.nvc = bus_wdata_in[9:0];
      end else if (bus_addr_in[7]) begin
        nx.regs[bus_addr_in[6:2]] = bus_wdata_in[9:0];
      end
    end
    // software reads, data stand only in the next cycle
    if (bus_rd_in) begin
      if (bus_addr_in == srasl_pkg::OFS_IRQ_STATUS) begin
        nx.rdata = {28'h0, st.status};
      end else if (bus_addr_in == srasl_pkg::OFS_IRQ_MASK) begin
        nx.rdata = {28'h0, st.mask};
      end else if (bus_addr_in == srasl_pkg::OFS_DIAG) begin
        nx.rdata = {19'h0, st.diag};
      end else if (bus_addr_in == srasl_pkg::OFS_NVC) begin
        nx.rdata = {22'h0, st.nvc};
      end else if (bus_addr_in == srasl_pkg::OFS_LINK) begin
        nx.rdata = {16'h0, st.fsm, st.idx, st.half, st.rw, st.oe_n};
      end else if (bus_addr_in[7]) begin
        nx.rdata = {22'h0, st.regs[bus_addr_in[6:2]]};
      end
    end
    // serial sequence; undervoltage beats everything
    if (st.uv_s2) begin
      nx.fsm  = srasl_pkg::SRASL_ST_IDLE;
      nx.oe_n = 1'b1;
    end else if (start_cond) begin
      nx.fsm    = srasl_pkg::SRASL_ST_ADDR;
      nx.bitcnt = 4'h0;
      nx.half   = 1'b0;                              // partial word dropped
      nx.oe_n   = 1'b1;
    end else if (stop_cond) begin
      nx.fsm  = srasl_pkg::SRASL_ST_IDLE;
      nx.oe_n = 1'b1;
      nx.status[srasl_pkg::IRQ_STOP] = 1'b1;
    end else begin
      // all SDA changes below happen on SCL falls only
      unique case (st.fsm)
        srasl_pkg::SRASL_ST_IDLE, srasl_pkg::SRASL_ST_WAIT: begin
          nx.oe_n = 1'b1;
        end
        srasl_pkg::SRASL_ST_ADDR: begin
          if (scl_rise) begin
            nx.shreg  = {st.shreg[6:0], st.sda_s2};
            nx.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == srasl_pkg::BIT_LAST) begin
            if (st.shreg[7:6] == 2'b00) begin
              nx.idx  = st.shreg[5:1];
              nx.rw   = st.shreg[0];
              nx.oe_n = 1'b0;
              nx.fsm  = srasl_pkg::SRASL_ST_ADDR_ACK;
            end else begin
              nx.fsm  = srasl_pkg::SRASL_ST_WAIT;
              nx.status[srasl_pkg::IRQ_ADDR_BAD] = 1'b1;
            end
          end
        end
        srasl_pkg::SRASL_ST_ADDR_ACK: begin
          if (scl_fall) begin
            nx.bitcnt = 4'h0;
            nx.half   = 1'b0;
            if (st.rw) begin
              word        = srasl_read_word(st.regs, st.diag, st.nvc, st.idx);
              nx.shreg    = word[15:8];
              nx.byte_buf = word[7:0];
              nx.oe_n     = word[15];
              nx.fsm      = srasl_pkg::SRASL_ST_RD_BYTE;
            end else begin
              nx.oe_n = 1'b1;
              nx.fsm  = srasl_pkg::SRASL_ST_WR_BYTE;
            end
          end
        end
        srasl_pkg::SRASL_ST_WR_BYTE: begin
          if (scl_rise) begin
            nx.shreg  = {st.shreg[6:0], st.sda_s2};
            nx.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == srasl_pkg::BIT_LAST) begin
            nx.oe_n = 1'b0;
            nx.fsm  = srasl_pkg::SRASL_ST_WR_ACK;
            if (!st.half) begin
              nx.byte_buf = st.shreg;
              nx.half     = 1'b1;
            end else begin
              commit  = 1'b1;
              nx.regs[st.idx] = {st.byte_buf[1:0], st.shreg};
              nx.idx  = st.idx + 5'h01;
              nx.half = 1'b0;
              nx.status[srasl_pkg::IRQ_WORD_WR] = 1'b1;
            end
          end
        end
        srasl_pkg::SRASL_ST_WR_ACK: begin
          if (scl_fall) begin
            nx.oe_n   = 1'b1;
            nx.bitcnt = 4'h0;
            nx.fsm    = srasl_pkg::SRASL_ST_WR_BYTE;
          end
        end
        srasl_pkg::SRASL_ST_RD_BYTE: begin
          if (scl_rise) begin
            nx.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (st.bitcnt == srasl_pkg::BIT_LAST) begin
              nx.oe_n = 1'b1;
              nx.fsm  = srasl_pkg::SRASL_ST_RD_ACK;
            end else begin
              nx.shreg = {st.shreg[6:0], 1'b0};
              nx.oe_n  = st.shreg[6];
            end
          end
        end
        srasl_pkg::SRASL_ST_RD_ACK: begin
          if (scl_rise) begin
            nx.rd_ack = ~st.sda_s2;
          end else if (scl_fall) begin
            if (st.rd_ack) begin
              nx.bitcnt = 4'h0;
              nx.fsm    = srasl_pkg::SRASL_ST_RD_BYTE;
              if (!st.half) begin
                nx.shreg = st.byte_buf;
                nx.half  = 1'b1;
                nx.oe_n  = st.byte_buf[7];
              end else begin
                word        = srasl_read_word(st.regs, st.diag, st.nvc, st.idx + 5'h01);
                nx.idx      = st.idx + 5'h01;
                nx.shreg    = word[15:8];
                nx.byte_buf = word[7:0];
                nx.half     = 1'b0;
                nx.oe_n     = word[15];
                nx.status[srasl_pkg::IRQ_WORD_RD] = 1'b1;
              end
            end else begin
              nx.oe_n = 1'b1;
              nx.fsm  = srasl_pkg::SRASL_ST_WAIT;
              if (st.half) begin
                nx.status[srasl_pkg::IRQ_WORD_RD] = 1'b1;
              end
            end
          end
        end
        default: begin
          // illegal one-hot code: fall back to a released idle
          nx.fsm  = srasl_pkg::SRASL_ST_IDLE;
          nx.oe_n = 1'b1;
        end
      endcase
    end
    nx.sda_lvl = 1'b0;                   // open drain only ever pulls low
    nx.irq     = |(nx.status & nx.mask);
  end

  // single state register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st <= srasl_pkg::SRASL_RST;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from state flops
  assign sda_out       = st.sda_lvl;
  assign sda_oe_n_out  = st.oe_n;
  assign bus_rdata_out = st.rdata;
  assign irq_out       = st.irq;

  // helper flops for the storage check
  logic       hlp_valid;
  logic [4:0] hlp_idx;
  logic [9:0] hlp_data;
  always_ff @(posedge clk_sys_in) begin
    hlp_valid <= commit & ~sys_rst_in;
    hlp_idx   <= st.idx;
    hlp_data  <= {st.byte_buf[1:0], st.shreg};
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  property p_start_restart;
    start_cond && !st.uv_s2 |=> st.fsm == srasl_pkg::SRASL_ST_ADDR && st.oe_n && !st.half;
  endproperty
  a_start_restart: assert property (p_start_restart) else $error("start not restarting");

  property p_uv_silent;
    st.uv_s2 |=> st.oe_n && st.fsm == srasl_pkg::SRASL_ST_IDLE;
  endproperty
  a_uv_silent: assert property (p_uv_silent) else $error("traffic answered in uv");

  property p_stop_idle;
    stop_cond && !st.uv_s2 && !start_cond |=> st.fsm == srasl_pkg::SRASL_ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not ending transfer");

  property p_bad_addr;
    st.fsm == srasl_pkg::SRASL_ST_ADDR && scl_fall && st.bitcnt == srasl_pkg::BIT_LAST
      && st.shreg[7:6] != 2'b00 && !st.uv_s2 |=> st.fsm == srasl_pkg::SRASL_ST_WAIT && st.oe_n;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("bad address acked");

  property p_ack_low;
    st.fsm == srasl_pkg::SRASL_ST_ADDR_ACK || st.fsm == srasl_pkg::SRASL_ST_WR_ACK
      |-> !st.oe_n;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");

  property p_store;
    hlp_valid |-> st.regs[hlp_idx] == hlp_data && st.idx == hlp_idx + 5'h01;
  endproperty
  a_store: assert property (p_store) else $error("write word not stored");

  property p_no_partial;
    !commit && !bus_wr_in |=> st.regs == $past(st.regs);
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("register changed early");

  property p_sda_on_low;
    st.scl_s2 && st.scl_s3 && !start_cond && !stop_cond && !st.uv_s2 |=> $stable(st.oe_n);
  endproperty
  a_sda_on_low: assert property (p_sda_on_low) else $error("SDA moved while SCL high");

  property p_nack_wait;
    st.fsm == srasl_pkg::SRASL_ST_RD_ACK && scl_fall && !st.rd_ack && !st.uv_s2
      |=> st.fsm == srasl_pkg::SRASL_ST_WAIT ##1 st.oe_n;
  endproperty
  a_nack_wait: assert property (p_nack_wait) else $error("nack not ending read");

  // the master owns SDA for the ninth clock of every read byte
  property p_rd_release;
    st.fsm == srasl_pkg::SRASL_ST_RD_BYTE && scl_fall && st.bitcnt == srasl_pkg::BIT_LAST
      && !st.uv_s2 |=> st.fsm == srasl_pkg::SRASL_ST_RD_ACK && st.oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("sda held into master ack");

  property p_rd_next;
    st.fsm == srasl_pkg::SRASL_ST_RD_ACK && scl_fall && st.rd_ack && st.half && !st.uv_s2
      |=> st.idx == $past(st.idx) + 5'h01 && st.shreg[7:2] == st.diag[12:7];
  endproperty
  a_rd_next: assert property (p_rd_next) else $error("read not advancing");

  property p_irq_level;
    ##1 irq_out == |(st.status & st.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level mismatch");

  c_write_word: cover property (commit);
  c_read_run:   cover property (st.fsm == srasl_pkg::SRASL_ST_RD_ACK && scl_fall && st.rd_ack);
  c_nack:       cover property (st.fsm == srasl_pkg::SRASL_ST_RD_ACK && scl_fall && !st.rd_ack);
  c_restart:    cover property (start_cond && st.half && st.fsm == srasl_pkg::SRASL_ST_WR_BYTE);
endmodule : srasl_slave

/* sim/srasl_host.sv */
// two-wire bus master model that drives the slave's serial pins
module srasl_host (
  input  wire logic clk_in,     // bench clock, paces every link step
  input  wire logic sda_in,     // resolved wire level
  output logic      scl_out,    // serial clock, idles high
  output logic      sda_rel_out // high releases sda, low pulls it
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    scl_out     = 1'b1;
    sda_rel_out = 1'b1;
  end

  // wait a number of system clocks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_clk

  // start: sda falls while scl high, also used as repeated start
  task automatic send_start();
    scl_out <= 1'b0;
    wait_clk(2);
    sda_rel_out <= 1'b1;
    wait_clk(3);
    scl_out <= 1'b1;
    wait_clk(5);
    sda_rel_out <= 1'b0;
    wait_clk(5);
  endtask : send_start

  // stop: sda rises while scl high
  task automatic send_stop();
    scl_out <= 1'b0;
    wait_clk(2);
    sda_rel_out <= 1'b0;
    wait_clk(3);
    scl_out <= 1'b1;
    wait_clk(5);
    sda_rel_out <= 1'b1;
    wait_clk(5);
  endtask : send_stop

  // one driven bit; sda moves only in the low half, period 10 clocks
  task automatic put_bit(input logic b);
    scl_out <= 1'b0;
    wait_clk(2);
    sda_rel_out <= b;
    wait_clk(3);
    scl_out <= 1'b1;
    wait_clk(5);
  endtask : put_bit

  // one received bit; sda released, sampled late in the high half
  task automatic get_bit(output logic b);
    scl_out <= 1'b0;
    wait_clk(2);
    sda_rel_out <= 1'b1;
    wait_clk(3);
    scl_out <= 1'b1;
    wait_clk(4);
    b = sda_in;
    wait_clk(1);
  endtask : get_bit

  // byte out msb first, then ninth clock for the slave's ack
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask : byte_wr

  // byte in msb first, then our ack (0) or nack (1)
  task automatic byte_rd(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(nack);
  endtask : byte_rd
endmodule : srasl_host

/* sim/srasl_slave_tb.sv */
// self-checking bench for the two-wire register access slave
module srasl_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] CRIT  = 6'h2a;  // critical flag pattern
  localparam logic [6:0] FLAGS = 7'h55;  // diagnostic flag pattern
  localparam logic [9:0] NVCNT = 10'h3a5; // write cycle count pattern

  logic        clk_sys_in = 1'b0;  // system clock
  logic        sys_rst_in = 1'b1;  // reset, held at start
  logic        scl;                // serial clock from host
  logic        sda_rel;            // host sda release
  logic        sda_out;            // slave open-drain value
  logic        sda_oe_n;           // slave pull enable, low pulls
  logic        uv         = 1'b0;  // logic supply undervoltage
  logic [7:0]  bus_addr   = 8'h00; // software address
  logic [31:0] bus_wdata  = '0;    // software write data
  logic        bus_wr     = 1'b0;  // write strobe
  logic        bus_rd     = 1'b0;  // read strobe
  logic [31:0] rdata;              // software read data
  logic [31:0] got;                // captured read value
  logic        irq;                // interrupt level
  logic        ack;                // ack seen by host
  int          error_cnt       = 0;
  int          samples_checked = 0;
  // pull-up wired-and of both parties
  wire logic   sda_wire = sda_rel & (sda_oe_n | sda_out);

  // 125 MHz clock
  always #4 clk_sys_in = ~clk_sys_in;

  srasl_slave i_srasl_slave (
    .clk_sys_in        (clk_sys_in),
    .sys_rst_in        (sys_rst_in),
    .scl_in            (scl),
    .sda_in            (sda_wire),
    .sda_out           (sda_out),
    .sda_oe_n_out      (sda_oe_n),
    .logic_supply_uv_in(uv),
    .bus_addr_in       (bus_addr),
    .bus_wdata_in      (bus_wdata),
    .bus_wr_in         (bus_wr),
    .bus_rd_in         (bus_rd),
    .bus_rdata_out     (rdata),
    .irq_out           (irq)
  );

  srasl_host i_srasl_host (
    .clk_in     (clk_sys_in),
    .sda_in     (sda_wire),
    .scl_out    (scl),
    .sda_rel_out(sda_rel)
  );

  // verdict and end of run
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // compare one value, four-state exact
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys_in);
    bus_wr <= 1'b0;
  endtask : bus_write

  // one-cycle read strobe, data taken in the following cycle
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys_in);
    bus_rd <= 1'b0;
    @(posedge clk_sys_in);
    d = rdata;
  endtask : bus_read

  // serial byte to the slave with expected ack level
  task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
    i_srasl_host.byte_wr(d, ack);
    chk("ack", {31'h0, exp_ack}, {31'h0, ack});
  endtask : wr_byte

  // serial word from the slave, last one nacked
  task automatic rd_word(input logic [15:0] exp, input logic last);
    logic [7:0] hi;
    logic [7:0] lo;
    i_srasl_host.byte_rd(hi, 1'b0);
    i_srasl_host.byte_rd(lo, last);
    chk("word", {16'h0, exp}, {16'h0, hi, lo});
  endtask : rd_word

  // software read compared in one line
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus_read(a, got);
    chk(what, exp, got);
  endtask : rd_chk

  // watchdog, far beyond the ~3200 cycles the tests take
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd_chk("mask", srasl_pkg::OFS_IRQ_MASK, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    bus_write(srasl_pkg::OFS_DIAG, {19'h0, CRIT, FLAGS});
    bus_write(srasl_pkg::OFS_NVC, {22'h0, NVCNT});
    bus_write(srasl_pkg::OFS_IRQ_MASK, 32'h1);
    rd_chk("diag", srasl_pkg::OFS_DIAG, {19'h0, CRIT, FLAGS});
    bus_write(srasl_pkg::OFS_REGS + 8'h74, 32'h155);
    // two words from index 3, top six bits dropped
    i_srasl_host.send_start();
    wr_byte({2'b00, 5'h03, 1'b0}, 1'b0);
    wr_byte(8'hff, 1'b0);
    wr_byte(8'hff, 1'b0);
    wr_byte(8'h12, 1'b0);
    wr_byte(8'h34, 1'b0);
    i_srasl_host.send_stop();
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk("status", srasl_pkg::OFS_IRQ_STATUS, 32'h5);
    @(posedge clk_sys_in);
    chk("irq", 32'h0, {31'h0, irq});
    chk("rdata idle", 32'h0, rdata);
    rd_chk("reg3", srasl_pkg::OFS_REGS + 8'h0c, 32'h3ff);
    rd_chk("reg4", srasl_pkg::OFS_REGS + 8'h10, 32'h234);
    // half word then repeated start, then read index 5 back
    i_srasl_host.send_start();
    wr_byte({2'b00, 5'h05, 1'b0}, 1'b0);
    wr_byte(8'h01, 1'b0);
    i_srasl_host.send_start();
    wr_byte({2'b00, 5'h05, 1'b1}, 1'b0);
    rd_word({CRIT, 10'h000}, 1'b1);
    i_srasl_host.send_stop();
    // half word then stop
    i_srasl_host.send_start();
    wr_byte({2'b00, 5'h06, 1'b0}, 1'b0);
    wr_byte(8'h03, 1'b0);
    i_srasl_host.send_stop();
    rd_chk("reg6", srasl_pkg::OFS_REGS + 8'h18, 32'h0);
    // run-on read of two words, ended by nack
    i_srasl_host.send_start();
    wr_byte({2'b00, 5'h03, 1'b1}, 1'b0);
    rd_word({CRIT, 10'h3ff}, 1'b0);
    rd_word({CRIT, 10'h234}, 1'b1);
    chk("release", 32'h1, {31'h0, sda_oe_n});
    i_srasl_host.byte_rd(got[7:0], 1'b1);
    chk("idle byte", 32'hff, {24'h0, got[7:0]});
    i_srasl_host.send_stop();
    rd_chk("status", srasl_pkg::OFS_IRQ_STATUS, 32'h6);
    // special layouts at 28, plain 29, diagnostic 30
    i_srasl_host.send_start();
    wr_byte({2'b00, srasl_pkg::IDX_NVCTRL, 1'b1}, 1'b0);
    rd_word({CRIT, NVCNT}, 1'b0);
    rd_word({CRIT, 10'h155}, 1'b0);
    rd_word({CRIT, FLAGS, 3'b000}, 1'b1);
    i_srasl_host.send_stop();
    // top address bits not zero: no ack, masked event keeps irq low
    i_srasl_host.send_start();
    wr_byte({2'b10, 5'h03, 1'b0}, 1'b1);
    i_srasl_host.send_stop();
    chk("irq", 32'h0, {31'h0, irq});
    bus_read(srasl_pkg::OFS_IRQ_STATUS, got);
    chk("bad addr", 32'h8, got & 32'h8);
    // traffic ignored under undervoltage, answered after
    uv <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    i_srasl_host.send_start();
    wr_byte({2'b00, 5'h07, 1'b0}, 1'b1);
    wr_byte(8'h02, 1'b1);
    wr_byte(8'h5a, 1'b1);
    i_srasl_host.send_stop();
    uv <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd_chk("reg7", srasl_pkg::OFS_REGS + 8'h1c, 32'h0);
    i_srasl_host.send_start();
    wr_byte({2'b00, 5'h07, 1'b0}, 1'b0);
    wr_byte(8'h02, 1'b0);
    wr_byte(8'h5a, 1'b0);
    i_srasl_host.send_stop();
    rd_chk("reg7", srasl_pkg::OFS_REGS + 8'h1c, 32'h25a);
    rd_chk("link", srasl_pkg::OFS_LINK, 32'h0000_0141);
    close_out();
  end
endmodule : srasl_slave_tb
